// ==== design/bdu_pkg.sv ====
// Package for the breakpoint debug unit: register layout, encodings, carriers
// What this block does
// - Execution breakpoint raises exception 1 fault beforehand
// - Execution match only on instruction first byte
// - Debug registers accessible in real mode or ring 0
// - Guard bit faults any debug register access made in real mode or ring 0
// - Handler entry clears the guard bit
// - Data breakpoints always reported exactly
// - Task switch clears task exact-match bit and task-local enables
// - Either enable arms a breakpoint
// - Task switch clears all task-local enables
// - Status flags set by hardware, cleared only by software write
// - Any enabled hit records all matching breakpoints
// - Execution hit is fault, data hit is trap
// - Guarded access sets guard hit flag
// - Single step sets step hit flag
// - Trapped task switch sets flag, traps first
// - Resume suppress masks execution breakpoint at return
// - Width codes 00 byte, 01 word, 11 dword
// - Type codes 00 execute, 01 write, 11 read/write
// - Data access overlapping field is a match
// - Reset leaves all breakpoints disabled
package bdu_pkg;

    // =========================================================
    // Register selects on the debug register port
    localparam logic [2:0] SEL_ADDR0 = 3'h0;
    localparam logic [2:0] SEL_ADDR3 = 3'h3;
    localparam logic [2:0] SEL_STATUS = 3'h6;
    localparam logic [2:0] SEL_CONTROL = 3'h7;

    // =========================================================
    // Control register fields
    localparam int CTL_EN_POS = 0;
    localparam int CTL_EXACT_TASK_POS = 8;
    localparam int CTL_EXACT_GLOBAL_POS = 9;
    localparam int CTL_GUARD_POS = 13;
    localparam int CTL_TYPE_POS = 16;
    localparam int CTL_WIDTH_POS = 18;
    localparam int CTL_FIELD_STRIDE = 4;
    localparam logic [31:0] CTL_RESET = 32'h0000_0400;
    localparam logic [31:0] CTL_WMASK = 32'hFFFF_23FF;

    // =========================================================
    // Status register fields
    localparam int STS_GUARD_POS = 13;
    localparam int STS_STEP_POS = 14;
    localparam int STS_TASK_POS = 15;
    localparam logic [31:0] STS_RESET = 32'hFFFF_0FF0;
    localparam logic [31:0] STS_FIXED = 32'hFFFF_0FF0;
    localparam logic [31:0] STS_WMASK = 32'h0000_E00F;

    // =========================================================
    // Encodings
    typedef enum logic [1:0] {
        BDU_W_BYTE = 2'b00,
        BDU_W_WORD = 2'b01,
        BDU_W_UNDEF = 2'b10,
        BDU_W_DWORD = 2'b11
    } bdu_width_t;

    typedef enum logic [1:0] {
        BDU_T_EXEC = 2'b00,
        BDU_T_WRITE = 2'b01,
        BDU_T_UNDEF = 2'b10,
        BDU_T_RDWR = 2'b11
    } bdu_type_t;

    // One linear access offered by the pipeline
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [1:0] size_m1;
    } bdu_access_t;

    // Debug register request from the execution unit
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] sel;
        logic [31:0] wdata;
    } bdu_regreq_t;

endpackage

// ==== design/bdu_unit.sv ====
// Breakpoint debug unit: address compare, status capture, exception requests
`timescale 1ns/100ps
`default_nettype none
module bdu_unit #(
    parameter int NUM_BP = 4
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire bdu_pkg::bdu_access_t FETCH,
    input wire logic FETCH_FIRST,
    input wire logic RESUME_SUPPRESS,
    input wire bdu_pkg::bdu_access_t DATA_ACC,
    input wire logic DATA_WRITE,
    input wire logic DATA_DONE,
    input wire logic STEP_TRAP,
    input wire logic TASK_SWITCH,
    input wire logic TASK_TRAP_BIT,
    input wire logic REAL_MODE,
    input wire logic [1:0] PRIV_LEVEL,
    input wire bdu_pkg::bdu_regreq_t REG_REQ,
    input wire logic HANDLER_ENTRY,
    output logic [31:0] REG_RDATA,
    output logic REG_PRIV_FAULT,
    output logic EXC1_FAULT,
    output logic EXC1_TRAP,
    output logic EXACT_WAIT
);

    // =========================================================
    // Architectural state
    logic [31:0] addr_q [NUM_BP];
    logic [31:0] ctl_q;
    logic [31:0] sts_q;
    logic [31:0] rdata_q;
    logic data_pend_q;
    logic [NUM_BP-1:0] data_hit_q;
    logic [NUM_BP-1:0] data_en_hit_q;

    // =========================================================
    // Per-breakpoint match
    logic [NUM_BP-1:0] enabled;
    logic [NUM_BP-1:0] exec_match;
    logic [NUM_BP-1:0] data_match;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
            logic [1:0] wcode;
            logic [1:0] tcode;
            logic [31:0] mask;
            logic [31:0] acc_last;
            logic [31:0] fld_lo;
            logic [31:0] fld_hi;
            assign wcode = ctl_q[bdu_pkg::CTL_WIDTH_POS + gi*bdu_pkg::CTL_FIELD_STRIDE +: 2];
            assign tcode = ctl_q[bdu_pkg::CTL_TYPE_POS + gi*bdu_pkg::CTL_FIELD_STRIDE +: 2];
            assign enabled[gi] = ctl_q[bdu_pkg::CTL_EN_POS + 2*gi]
                | ctl_q[bdu_pkg::CTL_EN_POS + 2*gi + 1];
            always_comb begin
                unique case (bdu_pkg::bdu_width_t'(wcode))
                    bdu_pkg::BDU_W_WORD: mask = 32'hFFFF_FFFE;
                    bdu_pkg::BDU_W_DWORD: mask = 32'hFFFF_FFFC;
                    default: mask = 32'hFFFF_FFFF;
                endcase
            end
            assign fld_lo = addr_q[gi] & mask;
            assign fld_hi = fld_lo | ~mask;
            assign acc_last = DATA_ACC.addr + {30'h0000_0000, DATA_ACC.size_m1};
            // exact address, first byte of instruction only
            assign exec_match[gi] = FETCH.valid && FETCH_FIRST && !RESUME_SUPPRESS
                && tcode == bdu_pkg::BDU_T_EXEC && FETCH.addr == fld_lo;
            // any overlap of access and field
            assign data_match[gi] = DATA_ACC.valid
                && (tcode == bdu_pkg::BDU_T_RDWR
                    || (tcode == bdu_pkg::BDU_T_WRITE && DATA_WRITE))
                && DATA_ACC.addr <= fld_hi && acc_last >= fld_lo;
        end
    endgenerate

    // =========================================================
    // Register access permission and guard
    logic reg_access;
    logic priv_ok;
    logic guard_fault;
    logic reg_ok;
    assign reg_access = REG_REQ.rd | REG_REQ.wr;
    assign priv_ok = REAL_MODE | (PRIV_LEVEL == 2'b00);
    assign guard_fault = reg_access && priv_ok && ctl_q[bdu_pkg::CTL_GUARD_POS];
    assign reg_ok = reg_access && priv_ok && !ctl_q[bdu_pkg::CTL_GUARD_POS];

    logic exec_hit;
    logic task_trap;
    logic data_trap;
    assign exec_hit = |(exec_match & enabled);
    assign task_trap = TASK_SWITCH & TASK_TRAP_BIT;
    // Data trap is held until the operand transfer finishes, so it is exact
    assign data_trap = data_pend_q & DATA_DONE;

    // =========================================================
    // Exception requests, combinational so they land before execution
    assign EXC1_FAULT = exec_hit | guard_fault;
    assign EXC1_TRAP = data_trap | STEP_TRAP | task_trap;
    assign REG_PRIV_FAULT = reg_access & ~priv_ok;
    assign EXACT_WAIT = data_pend_q;
    assign REG_RDATA = rdata_q;

    // =========================================================
    // Pending data breakpoint
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            data_pend_q <= 1'b0;
            data_hit_q <= '0;
            data_en_hit_q <= '0;
        end else if (data_trap) begin
            data_pend_q <= 1'b0;
            data_hit_q <= '0;
            data_en_hit_q <= '0;
        end else if (|(data_match & enabled)) begin
            data_pend_q <= 1'b1;
            data_hit_q <= data_hit_q | data_match;
            data_en_hit_q <= data_en_hit_q | (data_match & enabled);
        end
    end

    // =========================================================
    // Breakpoint address registers
    generate
        for (gi = 0; gi < NUM_BP; gi++) begin : g_addr
            always_ff @(posedge CLOCK or negedge RST_N) begin
                if (!RST_N) begin
                    addr_q[gi] <= 32'h0000_0000;
                end else if (reg_ok && REG_REQ.wr && REG_REQ.sel == 3'(gi)) begin
                    addr_q[gi] <= REG_REQ.wdata;
                end
            end
        end
    endgenerate

    // =========================================================
    // Control register
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_q <= bdu_pkg::CTL_RESET;
        end else begin
            logic [31:0] c;
            c = ctl_q;
            if (reg_ok && REG_REQ.wr && REG_REQ.sel == bdu_pkg::SEL_CONTROL) begin
                c = (REG_REQ.wdata & bdu_pkg::CTL_WMASK)
                    | (bdu_pkg::CTL_RESET & ~bdu_pkg::CTL_WMASK);
            end
            if (TASK_SWITCH) begin
                for (int i = 0; i < NUM_BP; i++) begin
                    c[bdu_pkg::CTL_EN_POS + 2*i] = 1'b0;
                end
                c[bdu_pkg::CTL_EXACT_TASK_POS] = 1'b0;
            end
            if (HANDLER_ENTRY) begin
                c[bdu_pkg::CTL_GUARD_POS] = 1'b0;
            end
            ctl_q <= c;
        end
    end

    // =========================================================
    // Status register: software write replaces, hardware only sets
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sts_q <= bdu_pkg::STS_RESET;
        end else begin
            logic [31:0] s;
            s = sts_q;
            if (reg_ok && REG_REQ.wr && REG_REQ.sel == bdu_pkg::SEL_STATUS) begin
                s = (REG_REQ.wdata & bdu_pkg::STS_WMASK) | bdu_pkg::STS_FIXED;
            end
            // Sets are applied after the write so a same-cycle event wins
            if (exec_hit) begin
                s[NUM_BP-1:0] = s[NUM_BP-1:0] | exec_match;
            end
            if (data_trap) begin
                s[NUM_BP-1:0] = s[NUM_BP-1:0] | data_hit_q;
            end
            if (guard_fault) begin
                s[bdu_pkg::STS_GUARD_POS] = 1'b1;
            end
            if (STEP_TRAP) begin
                s[bdu_pkg::STS_STEP_POS] = 1'b1;
            end
            if (task_trap) begin
                s[bdu_pkg::STS_TASK_POS] = 1'b1;
            end
            sts_q <= s;
        end
    end

    // =========================================================
    // Read data, registered one cycle after the read
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_ok && REG_REQ.rd) begin
            if (REG_REQ.sel <= bdu_pkg::SEL_ADDR3) begin
                rdata_q <= addr_q[REG_REQ.sel[1:0]];
            end else if (REG_REQ.sel == bdu_pkg::SEL_STATUS) begin
                rdata_q <= sts_q;
            end else if (REG_REQ.sel == bdu_pkg::SEL_CONTROL) begin
                rdata_q <= ctl_q;
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

endmodule
`default_nettype wire

// ==== sim/bdu_unit_chk.sv ====
// Concurrent checks on the breakpoint debug unit ports
`timescale 1ns/100ps
`default_nettype none
module bdu_unit_chk (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire bdu_pkg::bdu_access_t FETCH,
    input wire logic FETCH_FIRST,
    input wire logic RESUME_SUPPRESS,
    input wire logic DATA_DONE,
    input wire logic STEP_TRAP,
    input wire logic TASK_SWITCH,
    input wire logic TASK_TRAP_BIT,
    input wire logic REAL_MODE,
    input wire logic [1:0] PRIV_LEVEL,
    input wire bdu_pkg::bdu_regreq_t REG_REQ,
    input wire logic HANDLER_ENTRY,
    input wire logic REG_PRIV_FAULT,
    input wire logic EXC1_FAULT,
    input wire logic EXC1_TRAP,
    input wire logic EXACT_WAIT
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic req, ok, guard_q;
    assign req = REG_REQ.rd || REG_REQ.wr;
    assign ok = REAL_MODE || PRIV_LEVEL == 2'h0;
    // Shadow of the guard bit, so a guarded access can be recognised
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            guard_q <= 1'b0;
        end else if (HANDLER_ENTRY) begin
            guard_q <= 1'b0;
        end else if (REG_REQ.wr && ok && !guard_q && REG_REQ.sel == bdu_pkg::SEL_CONTROL) begin
            guard_q <= REG_REQ.wdata[bdu_pkg::CTL_GUARD_POS];
        end
    end
    // ==========
    // Assertions
    priv_fault_a: assert property (req && !ok |-> REG_PRIV_FAULT)
        else $error("privilege fault missing");
    guard_fault_a: assert property (guard_q && req && ok |-> EXC1_FAULT)
        else $error("guarded access not faulted");
    handler_clear_a: assert property ($past(HANDLER_ENTRY) && req && ok
        && !FETCH.valid |-> !EXC1_FAULT)
        else $error("guard still set after handler entry");
    not_first_a: assert property (!(FETCH.valid && FETCH_FIRST) && !req |-> !EXC1_FAULT)
        else $error("fault without first byte fetch");
    resume_mask_a: assert property (RESUME_SUPPRESS && !req |-> !EXC1_FAULT)
        else $error("fault while resume suppress");
    step_trap_a: assert property (STEP_TRAP |-> EXC1_TRAP)
        else $error("step trap missing");
    task_trap_a: assert property (TASK_SWITCH && TASK_TRAP_BIT |-> EXC1_TRAP)
        else $error("task switch trap missing");
    trap_cause_a: assert property (EXC1_TRAP |-> STEP_TRAP || TASK_SWITCH || DATA_DONE)
        else $error("trap without cause");
    exact_done_a: assert property (EXACT_WAIT && DATA_DONE |-> EXC1_TRAP)
        else $error("pending data hit not trapped");
    cover property (EXC1_FAULT && FETCH.valid);
    cover property (EXACT_WAIT && DATA_DONE);
    cover property (TASK_SWITCH && EXC1_TRAP);
endmodule
bind bdu_unit bdu_unit_chk u_chk (.*);
`default_nettype wire

// ==== sim/bdu_exec_model.sv ====
// Execution unit model: completes operand transfers after a stall
`timescale 1ns/100ps
`default_nettype none
module bdu_exec_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic acc_valid,
    input wire logic [1:0] stall,
    output logic data_done
);
    logic [2:0] cnt_q;
    // Next instruction waits until the transfer completes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
        end else if (acc_valid) begin
            cnt_q <= {1'b0, stall} + 3'h1;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    assign data_done = cnt_q == 3'h1;
endmodule
`default_nettype wire

// ==== sim/bdu_unit_tb.sv ====
// Self-checking bench for the breakpoint debug unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module bdu_unit_tb;
    logic CLOCK = 0;
    logic RST_N = 0;
    bdu_pkg::bdu_access_t FETCH = '0;
    bdu_pkg::bdu_access_t DATA_ACC = '0;
    bdu_pkg::bdu_regreq_t REG_REQ = '0;
    logic FETCH_FIRST = 0, RESUME_SUPPRESS = 0, DATA_WRITE = 0, STEP_TRAP = 0, TASK_SWITCH = 0;
    logic TASK_TRAP_BIT = 0, REAL_MODE = 1, HANDLER_ENTRY = 0, DATA_DONE, hit, seen;
    logic [1:0] PRIV_LEVEL = 0;
    logic [1:0] stall = 0;
    logic [31:0] REG_RDATA;
    logic REG_PRIV_FAULT, EXC1_FAULT, EXC1_TRAP, EXACT_WAIT;
    int mismatches = 0, cmp_count = 0, seed = 55, ctl = 'h400, sts, i, j, a, wc, t, sz;
    always #25 CLOCK = ~CLOCK;
    bdu_unit u_dut (.*);
    bdu_exec_model u_exec (.clock(CLOCK), .rst_n(RST_N), .acc_valid(DATA_ACC.valid),
        .stall(stall), .data_done(DATA_DONE));
    task automatic cyc(int n = 1);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask
    task automatic wr(logic [2:0] s, logic [31:0] d);
        REG_REQ = '{1'b0, 1'b1, s, d};
        cyc();
        REG_REQ = '0;
        if (s == 3'h7) ctl = d & bdu_pkg::CTL_WMASK | 'h400;
        if (s == 3'h6) sts = bdu_pkg::STS_FIXED | d & bdu_pkg::STS_WMASK;
        // One idle edge so the next request is never raised in the same step
        cyc();
    endtask
    task automatic rd(logic [2:0] s, int e);
        REG_REQ = '{1'b1, 1'b0, s, 32'h0};
        cyc();
        REG_REQ = '0;
        `CHK("rdata", e, REG_RDATA)
        cyc();
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Whole run is bounded; running out counts against the design
    initial begin
        #1000000;
        mismatches++;
        end_of_test();
    end
    // ==========
    // Main sequence
    initial begin
        sts = bdu_pkg::STS_RESET;
        cyc(8);
        RST_N = 1;
        cyc();
        rd(7, 'h400);
        rd(6, sts);
        wr(0, 32'h0000_1000);
        wr(1, 32'h0000_1000);
        wr(7, 32'h0000_0002);
        FETCH = '{1'b1, 32'h0000_1000, 2'h0};
        for (i = 0; i < 3; i++) begin
            FETCH_FIRST = i != 1;
            RESUME_SUPPRESS = i == 2;
            #5;
            `CHK("fault", i == 0, EXC1_FAULT)
            cyc();
        end
        FETCH = '0;
        rd(6, sts | 3);
        wr(2, 32'h0000_2005);
        // Random data accesses around a field at an odd address
        for (i = 0; i < 24; i++) begin
            wc = {$random(seed)} % 3;
            wc = wc == 2 ? 3 : wc;
            t = 1 + {$random(seed)} % 3;
            a = 'h2000 + {$random(seed)} % 12;
            sz = {$random(seed)} % 4;
            wr(6, 32'h0);
            wr(7, 32'h10 | t << 24 | wc << 26);
            DATA_WRITE = 1'($random(seed));
            stall = 2'($random(seed));
            hit = t != 2 && (t == 3 || DATA_WRITE)
                && a <= ('h2005 & ~wc) + wc && a + sz >= ('h2005 & ~wc);
            DATA_ACC = '{1'b1, a[31:0], sz[1:0]};
            cyc();
            DATA_ACC = '0;
            seen = 0;
            for (j = 0; j < 6; j++) begin
                #5;
                if (j == 0) `CHK("wait", hit, EXACT_WAIT)
                seen |= EXC1_TRAP;
                cyc();
            end
            `CHK("dtrap", hit, seen)
            `CHK("wait_end", 1'b0, EXACT_WAIT)
            sts |= hit << 2;
            rd(6, sts);
        end
        wr(7, 32'h0000_03FF);
        for (i = 0; i < 2; i++) begin
            STEP_TRAP = i == 0;
            TASK_SWITCH = i == 1;
            TASK_TRAP_BIT = 1;
            #5;
            `CHK("trap", 1'b1, EXC1_TRAP)
            cyc();
        end
        TASK_SWITCH = 0;
        STEP_TRAP = 0;
        cyc(20);
        rd(6, sts | 'hC000);
        rd(7, ctl & ~'h155);
        wr(7, 32'h0000_2000);
        REG_REQ = '{1'b1, 1'b0, 3'h7, 32'h0};
        #5;
        `CHK("gfault", 1'b1, EXC1_FAULT)
        cyc();
        REG_REQ = '0;
        HANDLER_ENTRY = 1;
        cyc();
        HANDLER_ENTRY = 0;
        rd(6, sts | 'hE000);
        rd(7, 'h400);
        REAL_MODE = 0;
        PRIV_LEVEL = 3;
        REG_REQ = '{1'b0, 1'b1, 3'h7, 32'h0000_00FF};
        #5;
        `CHK("pfault", 1'b1, REG_PRIV_FAULT)
        cyc();
        REG_REQ = '0;
        REAL_MODE = 1;
        PRIV_LEVEL = 0;
        rd(7, 'h400);
        wr(6, 32'h0);
        rd(6, sts);
        end_of_test();
    end
endmodule
`default_nettype wire
